// ==== design/dual_comparator_pkg.sv ====
// Constants, register map and mode codes for the dual comparator control block
package dual_comparator_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_INT_CTRL = 10'h00B;
  localparam logic [9:0] IDX_PERIPH_FLAGS = 10'h00C;
  localparam logic [9:0] IDX_CMP_CTRL = 10'h01F;
  localparam logic [9:0] IDX_PORT_A_DATA = 10'h005;
  localparam logic [9:0] IDX_PORT_A_DIR = 10'h085;
  localparam logic [9:0] IDX_PERIPH_EN = 10'h08C;
  localparam logic [9:0] IDX_REF_CTRL = 10'h09F;
  // Field positions
  localparam int GIE_BIT = 7;
  localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
  localparam int CMP_FLAG_BIT = 6;
  localparam int CMP_IE_BIT = 6;
  localparam int CIS_BIT = 3;
  // Reset values and write masks
  localparam logic [7:0] INT_CTRL_RST = 8'h00;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [4:0] PORT_DIR_RST = 5'h1F;
  localparam logic [4:0] PORT_DATA_RST = 5'h00;
  localparam logic [7:0] REF_CTRL_RST = 8'h00;
  localparam logic [7:0] REF_CTRL_MASK = 8'hEF;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] RD_ZERO = 32'h00000000;

  typedef enum logic [2:0] {
    MODE_RESET = 3'b000,
    MODE_ONE_OF_TWO = 3'b001,
    MODE_INT_REF = 3'b010,
    MODE_SHARED_REF = 3'b011,
    MODE_TWO_COMMON = 3'b100,
    MODE_ONE_ONLY = 3'b101,
    MODE_PIN_OUT = 3'b110,
    MODE_OFF = 3'b111
  } mode_t;

  // Which of pins 0..3 are analog inputs in each mode
  function automatic logic [3:0] analog_pins(input logic [2:0] m);
    case (m)
      MODE_RESET: analog_pins = 4'hF;
      MODE_ONE_OF_TWO: analog_pins = 4'hF;
      MODE_INT_REF: analog_pins = 4'hF;
      MODE_SHARED_REF: analog_pins = 4'h7;
      MODE_TWO_COMMON: analog_pins = 4'h3;
      MODE_ONE_ONLY: analog_pins = 4'h6;
      MODE_PIN_OUT: analog_pins = 4'h7;
      default: analog_pins = 4'h0;
    endcase
  endfunction : analog_pins
endpackage : dual_comparator_pkg

// ==== design/dual_comparator_control.sv ====
// Dual comparator control: AHB-Lite registers, change detect, pin routing
// Summary of operation
// R1: Mode 010 routes the internal reference to both non-inverting inputs.
// R2: Both results read back as bits 7:6, writes cannot change them.
// R3: Mode 110 drives pins 3 and 4 with raw comparator outputs.
// R4: Direction bits still enable pins 3 and 4 in that mode.
// R5: Port data reads return zero on analog-input pins.
// R6: Any result change sets the comparator change flag.
// R7: Software clears the flag with zero, or sets it with one.
// R8: Interrupt needs all three enables; flag sets regardless.
// R9: A change coinciding with a register read still sets the flag.
// R10: Any access to comparator control recaptures the change reference.
// R11: A lasting mismatch keeps setting the flag until recaptured.
// R12: Comparators keep running in sleep; enabled interrupt wakes device.
// R13: Mode 111 powers both comparators off.
// R14: Waking from sleep leaves comparator control unchanged.
// R15: Reset loads comparator control with mode 000.
// R16: Comparators stay powered down throughout reset.
// R17: Software waits response or settling time before trusting results.
// R18: External modes allow shared or separate reference pins.
// R19: Eight modes are selected by the three-bit mode field.
// R20: A result reads one when non-inverting input is higher.
// R21: Results are synchronised to the clock before readback and change detect.
// R22: Software masks the interrupt while changing mode.
`timescale 1ns/100ps
`default_nettype none
module dual_comparator_control
  import dual_comparator_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Analog comparator side
  input wire logic first_cmp_raw,
  input wire logic second_cmp_raw,
  output logic [2:0] comparator_mode_field,
  output logic input_switch_select,
  output logic internal_ref_select,
  output logic comparators_power_down,
  output logic [7:0] reference_control_out,
  // Port A pins 0..4
  input wire logic [4:0] port_a_in,
  output logic [4:0] port_a_out,
  output logic [4:0] port_a_oe_n,
  // CPU side
  input wire logic sleep_active,
  output logic cmp_irq,
  output logic cmp_wake
);
  import dual_comparator_pkg::*;

  logic busy_reg;
  logic wr_reg;
  logic [9:0] idx_reg;
  logic [7:0] int_ctrl_reg;
  logic flag_reg;
  logic flag_next;
  logic cmp_ie_reg;
  logic [2:0] mode_reg;
  logic cis_reg;
  logic [4:0] dir_reg;
  logic [4:0] data_reg;
  logic [7:0] ref_reg;
  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  logic [1:0] last_reg;
  logic [31:0] rd_next;
  logic ref_sel_reg;
  logic pwr_dn_reg;
  logic irq_reg;
  logic wake_reg;
  logic [4:0] pin_reg;
  logic [4:0] oe_n_reg;

  // Address phase and data phase decode
  wire logic take = hsel & hready & (htrans == HTRANS_NONSEQ);
  wire logic wr = busy_reg & wr_reg;
  wire logic sel_int = idx_reg == IDX_INT_CTRL;
  wire logic sel_flags = idx_reg == IDX_PERIPH_FLAGS;
  wire logic sel_cmp = idx_reg == IDX_CMP_CTRL;
  wire logic sel_data = idx_reg == IDX_PORT_A_DATA;
  wire logic sel_dir = idx_reg == IDX_PORT_A_DIR;
  wire logic sel_en = idx_reg == IDX_PERIPH_EN;
  wire logic sel_ref = idx_reg == IDX_REF_CTRL;
  wire logic cmp_access = busy_reg & sel_cmp;
  // Change detect compares the synchronised pair with the last captured pair
  wire logic mismatch = sync2_reg != last_reg;
  wire logic [4:0] analog_mask = {1'b0, analog_pins(mode_reg)};
  wire logic [7:0] cmp_ctrl_rd = {sync2_reg[1], sync2_reg[0], 2'b00, cis_reg, mode_reg};
  wire logic irq_next = flag_reg & cmp_ie_reg & int_ctrl_reg[PERIPHERAL_IRQ_ENABLE_BIT]
    & int_ctrl_reg[GIE_BIT];
  wire logic pin_mode = mode_reg == MODE_PIN_OUT;

  // Read mux; results come from the synchronised copy
  always_comb
  begin
    rd_next = RD_ZERO;
    if (sel_int)
      rd_next[7:0] = int_ctrl_reg;
    if (sel_flags)
      rd_next[CMP_FLAG_BIT] = flag_reg;
    if (sel_cmp)
      rd_next[7:0] = cmp_ctrl_rd; // see R2, see R20
    if (sel_data)
      rd_next[4:0] = port_a_in & ~analog_mask; // see R5
    if (sel_dir)
      rd_next[4:0] = dir_reg;
    if (sel_en)
      rd_next[CMP_IE_BIT] = cmp_ie_reg;
    if (sel_ref)
      rd_next[7:0] = ref_reg;
  end

  // Set wins over a software clear in the same cycle, so no change is lost
  always_comb
  begin
    flag_next = flag_reg;
    if (wr & sel_flags)
      flag_next = hwdata[CMP_FLAG_BIT]; // see R7
    if (mismatch)
      flag_next = 1'b1; // see R6, see R11, see R9
  end

  // Bus slave: one wait state per transfer
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_reg <= 1'b0;
      wr_reg <= 1'b0;
      idx_reg <= 10'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= RD_ZERO;
    end
    else
    begin
      hresp <= 1'b0;
      busy_reg <= take;
      if (take)
      begin
        wr_reg <= hwrite;
        // Misaligned addresses land on an unmapped index, so they read zero
        idx_reg <= (haddr[1:0] == 2'b00) ? haddr[11:2] : 10'h3FF;
      end
      hreadyout <= ~take;
      if (busy_reg)
        hrdata <= wr_reg ? RD_ZERO : rd_next;
    end
  end

  // Software registers; sleep does not touch them
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_ctrl_reg <= INT_CTRL_RST;
      cmp_ie_reg <= 1'b0;
      mode_reg <= MODE_RST; // see R15
      cis_reg <= 1'b0;
      dir_reg <= PORT_DIR_RST;
      data_reg <= PORT_DATA_RST;
      ref_reg <= REF_CTRL_RST;
    end
    else if (wr)
    begin
      if (sel_int)
        int_ctrl_reg <= hwdata[7:0];
      if (sel_en)
        cmp_ie_reg <= hwdata[CMP_IE_BIT];
      if (sel_cmp)
      begin
        mode_reg <= hwdata[2:0]; // see R19, see R18, see R14
        cis_reg <= hwdata[CIS_BIT];
      end
      if (sel_dir)
        dir_reg <= hwdata[4:0];
      if (sel_data)
        data_reg <= hwdata[4:0];
      if (sel_ref)
        ref_reg <= hwdata[7:0] & REF_CTRL_MASK;
    end
  end

  // Two-flop synchroniser, change reference and flag
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_reg <= 2'b00;
      sync2_reg <= 2'b00;
      last_reg <= 2'b00;
      flag_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= {second_cmp_raw, first_cmp_raw}; // see R21
      sync2_reg <= sync1_reg;
      if (cmp_access)
        last_reg <= sync2_reg; // see R10
      flag_reg <= flag_next;
    end
  end

  // Analog controls, interrupt, wake and pin drivers
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_sel_reg <= 1'b0;
      pwr_dn_reg <= 1'b1; // see R16
      irq_reg <= 1'b0;
      wake_reg <= 1'b0;
      pin_reg <= PORT_DATA_RST;
      oe_n_reg <= PORT_DIR_RST;
    end
    else
    begin
      ref_sel_reg <= mode_reg == MODE_INT_REF; // see R1
      pwr_dn_reg <= mode_reg == MODE_OFF; // see R13
      irq_reg <= irq_next; // see R8
      wake_reg <= sleep_active & flag_reg & cmp_ie_reg; // see R12
      pin_reg <= data_reg;
      oe_n_reg <= dir_reg; // see R4
    end
  end

  assign comparator_mode_field = mode_reg;
  assign input_switch_select = cis_reg;
  assign internal_ref_select = ref_sel_reg;
  assign comparators_power_down = pwr_dn_reg;
  assign reference_control_out = ref_reg;
  assign cmp_irq = irq_reg;
  assign cmp_wake = wake_reg;
  assign port_a_oe_n = oe_n_reg;
  // Raw path is unsynchronised by intent; a flop would add a clock of lag
  assign port_a_out = pin_mode ? {second_cmp_raw, first_cmp_raw, pin_reg[2:0]}
    : pin_reg; // see R3

  // Assertion helper: cycles a mismatch has lasted, saturating at seven
  logic [2:0] mismatch_age_reg;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      mismatch_age_reg <= 3'h0;
    else if (!mismatch)
      mismatch_age_reg <= 3'h0;
    else if (mismatch_age_reg != 3'h7)
      mismatch_age_reg <= mismatch_age_reg + 3'h1;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  chk_ref_route: assert property ((mode_reg == MODE_INT_REF) |=> internal_ref_select) // see R1
    else $error("internal reference not routed in mode 010");
  chk_result_read: assert property (busy_reg & sel_cmp & ~wr_reg |=>
    hrdata[7:6] == $past(sync2_reg)) // see R2
    else $error("comparator result bits read wrong");
  chk_pin_mux: assert property (pin_mode |-> port_a_out[4:3]
    == {second_cmp_raw, first_cmp_raw}) // see R3
    else $error("pins 3 and 4 not carrying comparator outputs");
  chk_dir_enable: assert property (##1 port_a_oe_n[4:3] == $past(dir_reg[4:3])) // see R4
    else $error("direction bits not enabling pins 3 and 4");
  chk_analog_zero: assert property (busy_reg & sel_data & ~wr_reg |=>
    (hrdata[3:0] & $past(analog_mask[3:0])) == 4'h0) // see R5
    else $error("analog pin read as nonzero");
  chk_flag_set: assert property (mismatch |=> flag_reg) // see R6
    else $error("result change did not set flag");
  chk_irq_gate: assert property (##1 cmp_irq == $past(irq_next)) // see R8
    else $error("interrupt gating wrong");
  chk_recapture: assert property (cmp_access |=> last_reg == $past(sync2_reg)) // see R10
    else $error("access did not recapture reference");
  chk_power_off: assert property ((mode_reg == MODE_OFF) |=> comparators_power_down) // see R13
    else $error("mode 111 did not power down");
  chk_bus_answer: assert property (take |=> !hreadyout ##1 hreadyout)
    else $error("bus answer not after one wait state");

  // Routing and power follow the mode field; stored fields follow writes
  chk_ref_off: assert property ((mode_reg != MODE_INT_REF) // see R1
    |=> !internal_ref_select)
    else $error("internal reference routed outside mode 010");
  chk_power_on: assert property ((mode_reg != MODE_OFF) // see R13
    |=> !comparators_power_down)
    else $error("comparators powered down outside mode 111");
  chk_mode_write: assert property (busy_reg & sel_cmp & wr_reg |=> // see R19
    comparator_mode_field == $past(hwdata[2:0]))
    else $error("mode field not taken from write");
  chk_cis_write: assert property (busy_reg & sel_cmp & wr_reg |=> // see R18
    input_switch_select == $past(hwdata[CIS_BIT]))
    else $error("input switch not taken from write");
  chk_mode_kept: assert property (!(wr & sel_cmp) |=> // see R14
    $stable(mode_reg))
    else $error("mode changed without a write");

  // Port pins outside the comparator-output path
  chk_pin_latch: assert property (!pin_mode |-> // see R3
    port_a_out == pin_reg)
    else $error("pins not driven from the data latch");
  chk_pin4_read: assert property (busy_reg & sel_data & ~wr_reg |=> // see R5
    hrdata[4] == $past(port_a_in[4]))
    else $error("digital pin 4 read wrong");

  // Flag set, clear and the lasting mismatch
  chk_sw_set: assert property (wr & sel_flags & hwdata[CMP_FLAG_BIT] |=> // see R7
    flag_reg)
    else $error("written one did not set flag");
  chk_sw_clear: assert property (wr & sel_flags & ~hwdata[CMP_FLAG_BIT] & ~mismatch // see R7
    |=> !flag_reg)
    else $error("written zero did not clear flag");
  chk_flag_hold: assert property (~mismatch & ~(wr & sel_flags) |=> // see R6
    flag_reg == $past(flag_reg))
    else $error("flag changed with no event");
  chk_clear_blocked: assert property (wr & sel_flags & mismatch |=> // see R11
    flag_reg)
    else $error("flag cleared during mismatch");
  chk_mismatch_age: assert property ((mismatch_age_reg != 3'h0) |-> // see R11
    flag_reg)
    else $error("flag low while mismatch lasts");
  chk_flag_read: assert property (busy_reg & sel_flags & ~wr_reg |=> // see R6
    hrdata[CMP_FLAG_BIT] == $past(flag_reg))
    else $error("flag read wrong");

  // Change reference and synchroniser
  chk_recapture_only: assert property (!cmp_access |=> // see R10
    last_reg == $past(last_reg))
    else $error("reference moved without an access");
  chk_sync_delay: assert property (##2 // see R21
    sync2_reg == $past({second_cmp_raw, first_cmp_raw}, 2))
    else $error("results not two clocks behind inputs");

  // Interrupt and wake gating
  chk_irq_off: assert property (!flag_reg |=> // see R8
    !cmp_irq)
    else $error("interrupt without flag");
  chk_irq_global: assert property (!int_ctrl_reg[GIE_BIT] |=> // see R8
    !cmp_irq)
    else $error("interrupt with global enable off");
  chk_wake_gate: assert property (##1 // see R12
    cmp_wake == $past(sleep_active & flag_reg & cmp_ie_reg))
    else $error("wake gating wrong");

  // Bus wait state, read data and reference register
  chk_wait_low: assert property (busy_reg |->
    !hreadyout)
    else $error("ready high during wait state");
  chk_write_rdzero: assert property (busy_reg & wr_reg |=>
    hrdata == RD_ZERO)
    else $error("write left read data nonzero");
  chk_unmapped_zero: assert property (busy_reg & ~wr_reg & (idx_reg == 10'h3FF) |=>
    hrdata == RD_ZERO)
    else $error("unmapped read nonzero");
  chk_ref_mask: assert property (busy_reg & sel_ref & wr_reg |=>
    reference_control_out == ($past(hwdata[7:0]) & REF_CTRL_MASK))
    else $error("reference register write wrong");

  // Main scenarios
  cov_pin_mode: cover property (pin_mode ##1 first_cmp_raw);
  cov_flag_rise: cover property ($rose(flag_reg));
  cov_irq: cover property ($rose(cmp_irq));
  cov_sw_set: cover property (wr & sel_flags & hwdata[CMP_FLAG_BIT] & ~mismatch);
  cov_wake: cover property ($rose(cmp_wake));
endmodule : dual_comparator_control
`default_nettype wire

// ==== dv/analog_source_model.sv ====
// Behavioural analog sources feeding both comparators
`timescale 1ns/100ps
`default_nettype none
module analog_source_model
(
  // Input levels of both comparators
  input wire logic [7:0] plus_a,
  input wire logic [7:0] minus_a,
  input wire logic [7:0] plus_b,
  input wire logic [7:0] minus_b,
  // Power state from the block
  input wire logic power_down,
  // Raw results
  output logic first_cmp_raw,
  output logic second_cmp_raw
);
  // Powered-down comparators sit low, so power changes look like real edges
  assign first_cmp_raw = !power_down && (plus_a > minus_a);
  assign second_cmp_raw = !power_down && (plus_b > minus_b);
endmodule : analog_source_model
`default_nettype wire

// ==== dv/test_dual_comparator_control.sv ====
// Self-checking testbench of the dual comparator control block
`timescale 1ns/100ps
`default_nettype none
module test_dual_comparator_control;
  import dual_comparator_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b1;
  logic hsel = 1'b1;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, first_cmp_raw, second_cmp_raw, input_switch_select;
  logic internal_ref_select, comparators_power_down, cmp_irq, cmp_wake;
  logic [2:0] comparator_mode_field;
  logic [7:0] reference_control_out;
  logic [7:0] plus_a = 8'h40, minus_a = 8'h80, plus_b = 8'h40, minus_b = 8'h80;
  logic [4:0] port_a_out, port_a_oe_n;
  logic [4:0] port_a_in = 5'h1F;
  logic sleep_active = 1'b0;
  int mismatches = 0;
  int cmp_count = 0;
  // Analog pins 3..0 per mode
  localparam logic [3:0] AMASK [8] = '{4'hF, 4'hF, 4'hF, 4'h7, 4'h3, 4'h6, 4'h7, 4'h0};

  always #12.5 clock = ~clock;

  dual_comparator_control u_dual_comparator_control (.clock(clock), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .first_cmp_raw(first_cmp_raw), .second_cmp_raw(second_cmp_raw),
    .comparator_mode_field(comparator_mode_field), .input_switch_select(input_switch_select),
    .internal_ref_select(internal_ref_select), .comparators_power_down(comparators_power_down),
    .reference_control_out(reference_control_out), .port_a_in(port_a_in),
    .port_a_out(port_a_out), .port_a_oe_n(port_a_oe_n), .sleep_active(sleep_active),
    .cmp_irq(cmp_irq), .cmp_wake(cmp_wake));

  analog_source_model u_analog_source_model (.plus_a(plus_a), .minus_a(minus_a),
    .plus_b(plus_b), .minus_b(minus_b), .power_down(comparators_power_down),
    .first_cmp_raw(first_cmp_raw), .second_cmp_raw(second_cmp_raw));

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask : idle

  // Bounded wait for hready sampled high at a rising edge
  task automatic wait_ready;
    int n;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1)
    begin
      mismatches++;
      complete_run();
    end
  endtask : wait_ready

  task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d);
    haddr <= {idx, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    wait_ready();
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask : wr

  task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00);
    check(rd, exp);
    check(hresp, 1'b0);
  endtask : rdc

  task automatic t_reset;
    rdc(IDX_CMP_CTRL, 32'h00000000);
    rdc(IDX_PORT_A_DIR, 32'h0000001F);
    rdc(IDX_PERIPH_FLAGS, 32'h00000000);
    rdc(IDX_PERIPH_EN, 32'h00000000);
    rdc(10'h3FF, 32'h00000000);
    wr(IDX_REF_CTRL, 8'hFF);
    check(reference_control_out, 8'hEF);
    rdc(IDX_REF_CTRL, 32'h000000EF);
  endtask : t_reset

  task automatic t_modes;
    logic [2:0] m;
    plus_a <= 8'hC0;
    for (int i = 0; i < 8; i++)
    begin
      m = i[2:0];
      wr(IDX_CMP_CTRL, {2'b11, 2'b00, m[0], m});
      port_a_in <= 5'h1F ^ {2'b00, m};
      idle(4);
      check(internal_ref_select, m == 3'b010);
      check(comparators_power_down, m == 3'b111);
      check(comparator_mode_field, m);
      check(input_switch_select, m[0]);
      rdc(IDX_CMP_CTRL, {24'h0, 1'b0, m != 3'b111, 2'b00, m[0], m});
      rdc(IDX_PORT_A_DATA, {27'h0, (5'h1F ^ {2'b00, m}) & ~{1'b0, AMASK[i]}});
    end
  endtask : t_modes

  task automatic t_pinout;
    wr(IDX_CMP_CTRL, 8'h06);
    wr(IDX_PORT_A_DIR, 8'h07);
    wr(IDX_PORT_A_DATA, 8'h05);
    idle(2);
    check(port_a_oe_n, 5'h07);
    check(port_a_out[4:3], 2'b01);
    check(port_a_out, 5'h0D);
    plus_b <= 8'hC0;
    // No edge in between: the pin path must not be synchronised
    @(negedge clock);
    check(port_a_out[4:3], 2'b11);
    @(posedge clock);
    wr(IDX_PORT_A_DIR, 8'h1F);
    idle(2);
    check(port_a_oe_n, 5'h1F);
  endtask : t_pinout

  task automatic t_flag;
    wr(IDX_INT_CTRL, 8'h00);
    wr(IDX_CMP_CTRL, 8'h02);
    idle(4);
    check(port_a_out, 5'h05);
    rdc(IDX_CMP_CTRL, 32'h000000C2);
    wr(IDX_PERIPH_FLAGS, 8'h00);
    rdc(IDX_PERIPH_FLAGS, 32'h00000000);
    wr(IDX_PERIPH_EN, 8'h40);
    wr(IDX_INT_CTRL, 8'hC0);
    idle(2);
    check(cmp_irq, 1'b0);
    plus_a <= 8'h00;
    idle(4);
    rdc(IDX_PERIPH_FLAGS, 32'h00000040);
    check(cmp_irq, 1'b1);
    wr(IDX_INT_CTRL, 8'h40);
    idle(2);
    check(cmp_irq, 1'b0);
    wr(IDX_PERIPH_FLAGS, 8'h00);
    rdc(IDX_PERIPH_FLAGS, 32'h00000040);
    rdc(IDX_CMP_CTRL, 32'h00000082);
    wr(IDX_PERIPH_FLAGS, 8'h00);
    rdc(IDX_PERIPH_FLAGS, 32'h00000000);
    wr(IDX_PERIPH_FLAGS, 8'h40);
    rdc(IDX_PERIPH_FLAGS, 32'h00000040);
    wr(IDX_PERIPH_FLAGS, 8'h00);
  endtask : t_flag

  task automatic t_sleep;
    sleep_active <= 1'b1;
    plus_a <= 8'hC0;
    idle(5);
    check(cmp_wake, 1'b1);
    sleep_active <= 1'b0;
    idle(2);
    check(cmp_wake, 1'b0);
    rdc(IDX_CMP_CTRL, 32'h000000C2);
  endtask : t_sleep

  initial
  begin
    rst_n <= 1'b0;
    repeat (10) @(posedge clock);
    check(comparators_power_down, 1'b1);
    rst_n <= 1'b1;
    @(posedge clock);
    t_reset();
    t_modes();
    t_pinout();
    t_flag();
    t_sleep();
    rst_n <= 1'b0;
    idle(2);
    check(comparators_power_down, 1'b1);
    check(comparator_mode_field, 3'h0);
    rst_n <= 1'b1;
    idle(2);
    complete_run();
  end
endmodule : test_dual_comparator_control
`default_nettype wire
